// File: verilog/dtcl_defs.svh
// Offsets, field positions, reset values, codes and timing of the terminal command logic
`ifndef DTCL_DEFS_SVH
`define DTCL_DEFS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define DTCL_OFS_CTRL 8'h00
`define DTCL_OFS_ASG0 8'h04
`define DTCL_OFS_DECEL 8'h18
`define DTCL_OFS_STAT 8'h1C
`define DTCL_OFS_MON 8'h20
// ****************************************
// Fields and reset values
// ****************************************
`define DTCL_CTRL_PROT 0
`define DTCL_CTRL_POL 1
`define DTCL_NTERM 5
`define DTCL_NIN 7
`define DTCL_ASG_NONE 11'h7FF
`define DTCL_RST_DECEL 16'h0064
`define DTCL_NEG_OFS 11'h3E8
`define DTCL_ALM_EXT 8'h01
`define DTCL_ALM_FSTOP 8'h02
// ****************************************
// Timing
// ****************************************
`define DTCL_CLK_NS 50
`define DTCL_TICK_NS 1000000
// ****************************************
// Assignment codes and function slots
// ****************************************
`define DTCL_NFN 17
`define DTCL_C_HLD 11'h006
`define DTCL_C_BX 11'h007
`define DTCL_C_RST 11'h008
`define DTCL_C_THR 11'h009
`define DTCL_C_HZ 11'h00B
`define DTCL_C_DCB 11'h00D
`define DTCL_C_WEKP 11'h013
`define DTCL_C_IVS 11'h015
`define DTCL_C_IL 11'h016
`define DTCL_C_LE 11'h018
`define DTCL_C_UDI 11'h019
`define DTCL_C_STM 11'h01A
`define DTCL_C_STOP 11'h01E
`define DTCL_C_LOC 11'h023
`define DTCL_C_DWP 11'h027
`define DTCL_C_FR 11'h057
`define DTCL_C_ALT_RUN_FORWARD 11'h058
`define DTCL_C_ALT_RUN_REVERSE 11'h059
`define DTCL_F_HLD 0
`define DTCL_F_BX 1
`define DTCL_F_RST 2
`define DTCL_F_THR 3
`define DTCL_F_HZ 4
`define DTCL_F_DCB 5
`define DTCL_F_WEKP 6
`define DTCL_F_IVS 7
`define DTCL_F_IL 8
`define DTCL_F_LE 9
`define DTCL_F_STM 10
`define DTCL_F_STOP 11
`define DTCL_F_LOC 12
`define DTCL_F_DWP 13
`define DTCL_F_FR 14
`define DTCL_F_ALT_RUN_FORWARD 15
`define DTCL_F_ALT_RUN_REVERSE 16
`endif

// File: verilog/dtcl_pkg.sv
// Types shared by the terminal command logic
package dtcl_pkg;
    // Forced stop sequence
    typedef enum logic [1:0] {
        DTCL_FS_IDLE = 2'b00,
        DTCL_FS_DECEL = 2'b01,
        DTCL_FS_ALARM = 2'b10
    } dtcl_fstop_t;
    // Run command sources
    typedef enum logic [1:0] {
        DTCL_RUN_TERM = 2'b00,
        DTCL_RUN_ALT = 2'b01,
        DTCL_RUN_KEYPAD = 2'b10,
        DTCL_RUN_COMM = 2'b11
    } dtcl_rsrc_t;
    // Frequency command sources
    typedef enum logic [1:0] {
        DTCL_FRQ_PRI = 2'b00,
        DTCL_FRQ_SEC = 2'b01,
        DTCL_FRQ_KEYPAD = 2'b10,
        DTCL_FRQ_COMM = 2'b11
    } dtcl_fsrc_t;
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] lvl;
    } dtcl_sync_st_t;
    typedef struct packed {
        logic run_fwd;
        logic run_rev;
        logic out_en;
        logic decel;
        logic dcb;
        logic heat;
        logic fault;
        logic [7:0] code;
        dtcl_fsrc_t fsrc;
        logic inv;
        logic restart;
        logic ss;
        dtcl_rsrc_t rsrc;
        logic [4:0] mon;
        logic edit_ok;
    } dtcl_out_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic prot;
        logic pol;
        logic [4:0][10:0] asg;
        logic [15:0] decel;
        logic lf;
        logic lr;
        logic fw_p;
        logic rv_p;
        logic rst_p;
        logic trip;
        logic run_p;
        dtcl_fstop_t fs;
        logic [14:0] tick_cnt;
        logic [15:0] dcnt;
        dtcl_out_t o;
    } dtcl_core_st_t;
endpackage

// File: verilog/dtcl_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
`include "dtcl_defs.svh"
module dtcl_sync (
    input wire logic clock, // Control clock
    input wire logic resetn, // Async reset, low
    input wire logic [`DTCL_NIN-1:0] raw, // Pin levels
    output logic [`DTCL_NIN-1:0] lvl // Settled levels
);
    dtcl_pkg::dtcl_sync_st_t st_q, st_d;
    logic [`DTCL_NIN-1:0] agree;

    // A change counts only once stages two and three agree
    always_comb begin
        st_d = st_q;
        agree = ~(st_q.s2 ^ st_q.s3);
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.lvl = (st_q.s2 & agree) | (st_q.lvl & ~agree);
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign lvl = st_q.lvl;
endmodule
`default_nettype wire

// File: verilog/dtcl_decode.sv
// Maps terminal assignment codes onto command levels
`timescale 1ns/1ps
`default_nettype none
`include "dtcl_defs.svh"
module dtcl_decode (
    input wire logic [`DTCL_NTERM-1:0][10:0] asg, // Codes
    input wire logic [`DTCL_NTERM-1:0] lvl, // Terminal levels
    output logic [`DTCL_NFN-1:0] fn_on, // Command active
    output logic [`DTCL_NFN-1:0] fn_asg, // Command assigned
    output logic [`DTCL_NTERM-1:0] mon // Monitor-only bits
);
    localparam logic [`DTCL_NFN-1:0][10:0] CODES = {
        `DTCL_C_ALT_RUN_REVERSE, `DTCL_C_ALT_RUN_FORWARD, `DTCL_C_FR, `DTCL_C_DWP,
        `DTCL_C_LOC, `DTCL_C_STOP, `DTCL_C_STM, `DTCL_C_LE,
        `DTCL_C_IL, `DTCL_C_IVS, `DTCL_C_WEKP, `DTCL_C_DCB,
        `DTCL_C_HZ, `DTCL_C_THR, `DTCL_C_RST, `DTCL_C_BX, `DTCL_C_HLD};
    // Fail-safe commands are active when the pin is off
    localparam logic [`DTCL_NFN-1:0] FSAFE = 17'h0_0808;
    // Commands with no active-off variant
    localparam logic [`DTCL_NFN-1:0] NONEG = 17'h1_A020;

    // Returns {assigned, invert} for one terminal and one command
    function automatic logic [1:0] match(input logic [10:0] c, input logic [10:0] b,
                                         input logic fs, input logic noneg);
        logic [10:0] nb;
        nb = 11'(b + `DTCL_NEG_OFS);
        if (c == b) begin
            match = {1'b1, fs};
        end else if (!noneg && c == nb) begin
            match = {1'b1, ~fs};
        end else begin
            match = 2'b00;
        end
    endfunction

    // OR every terminal carrying a command into its level
    always_comb begin
        logic [1:0] m;
        m = 2'b00;
        fn_on = '0;
        fn_asg = '0;
        mon = '0;
        for (int t = 0; t < `DTCL_NTERM; t++) begin
            for (int f = 0; f < `DTCL_NFN; f++) begin
                m = match(asg[t], CODES[f], FSAFE[f], NONEG[f]);
                fn_asg[f] = fn_asg[f] | m[1];
                fn_on[f] = fn_on[f] | (m[1] & (lvl[t] ^ m[0]));
            end
            m = match(asg[t], `DTCL_C_UDI, 1'b0, 1'b0);
            mon[t] = m[1] & (lvl[t] ^ m[0]);
        end
    end
endmodule
`default_nettype wire

// File: verilog/dtcl_core.sv
// Terminal command interpreter of the drive, with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
`include "dtcl_defs.svh"
module dtcl_core #(
    parameter int TICK_CYCLES = `DTCL_TICK_NS / `DTCL_CLK_NS // Cycles per 1 ms
) (
    input wire logic clock, // 20 MHz control clock
    input wire logic resetn, // Async reset, low
    input wire logic [7:0] address, // Avalon byte address
    input wire logic read, // Avalon read
    input wire logic write, // Avalon write
    input wire logic [31:0] writedata, // Avalon write data
    output logic [31:0] readdata, // Avalon read data
    output logic waitrequest, // Avalon wait
    input wire logic [`DTCL_NTERM-1:0] term_in, // Programmable terminals
    input wire logic run_forward_cmd, // Forward pin
    input wire logic run_reverse_cmd, // Reverse pin
    input wire logic motor_halted, // Motor at standstill
    input wire logic keypad_fwd, // Keypad forward run
    input wire logic keypad_rev, // Keypad reverse run
    input wire logic comm_fwd, // Link forward run
    input wire logic comm_rev, // Link reverse run
    output logic run_fwd_out, // Run forward
    output logic run_rev_out, // Run reverse
    output logic output_enable, // Output stage enabled
    output logic forced_decel, // Forced-stop ramp
    output logic dc_brake_on, // Continuous DC brake
    output logic heating_on, // Condensation heating
    output logic fault_relay_output, // Fault relay
    output logic [7:0] alarm_code, // Alarm shown, 0 none
    output logic [1:0] freq_src, // Frequency source
    output logic analog_invert, // Primary analog inverse
    output logic restart_enable, // Power failure seen
    output logic speed_search_en, // Search at start
    output logic [1:0] run_src, // Run command source
    output logic [`DTCL_NTERM-1:0] monitored_bits, // Monitor-only to link
    output logic keypad_edit_allowed // Edit other settings
);
    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [14:0] TICK_LAST = 15'(TICK_CYCLES - 1);
    dtcl_pkg::dtcl_core_st_t st_q, st_d;
    logic [`DTCL_NIN-1:0] sync_lvl;
    logic [`DTCL_NFN-1:0] fn_on, fn_asg;
    logic [`DTCL_NTERM-1:0] mon;
    logic fw, rv, req, tick, rst_rise, rst_fall, le, run_latch_enable;
    logic trip_now, fs_in, blocked, sf, sr, run_now;
    logic [3:0] slot;
    logic [31:0] rd_mux;

    // Hits the terminal assignment window; returns {hit, index}
    function automatic logic [3:0] asg_slot(input logic [7:0] a);
        logic [7:0] d;
        d = 8'(a - `DTCL_OFS_ASG0);
        asg_slot = {(d[1:0] == 2'b00) && (d[7:2] < 6'(`DTCL_NTERM)), d[4:2]};
    endfunction

    // ****************************************
    // Input capture and decoding
    // ****************************************
    dtcl_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .raw({run_reverse_cmd, run_forward_cmd, term_in}),
        .lvl(sync_lvl)
    );

    dtcl_decode u_dec (
        .asg(st_q.asg),
        .lvl(sync_lvl[`DTCL_NTERM-1:0]),
        .fn_on(fn_on),
        .fn_asg(fn_asg),
        .mon(mon)
    );

    // Named views of decoded commands
    assign fw = sync_lvl[`DTCL_NTERM];
    assign rv = sync_lvl[`DTCL_NTERM+1];
    assign run_latch_enable = fn_on[`DTCL_F_HLD];
    assign trip_now = fn_on[`DTCL_F_THR];
    assign fs_in = fn_on[`DTCL_F_STOP];
    assign le = ~fn_asg[`DTCL_F_LE] | fn_on[`DTCL_F_LE];
    assign rst_rise = fn_on[`DTCL_F_RST] & ~st_q.rst_p;
    assign rst_fall = ~fn_on[`DTCL_F_RST] & st_q.rst_p;
    assign tick = (st_q.tick_cnt == TICK_LAST);
    assign req = read | write;
    assign slot = asg_slot(address);

    // ****************************************
    // Register read mux
    // ****************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (slot[3]) begin
            rd_mux = {21'h00_0000, st_q.asg[slot[2:0]]};
        end else begin
            case (address)
                `DTCL_OFS_CTRL: begin
                    rd_mux = {30'h0000_0000, st_q.pol, st_q.prot};
                end
                `DTCL_OFS_DECEL: begin
                    rd_mux = {16'h0000, st_q.decel};
                end
                `DTCL_OFS_STAT: begin
                    rd_mux = {14'h0000, st_q.fs, st_q.o.code, 1'b0, ~st_q.o.out_en,
                              st_q.o.ss, st_q.lr, st_q.lf, st_q.trip, st_q.o.run_fwd | st_q.o.run_rev,
                              st_q.o.fault};
                end
                `DTCL_OFS_MON: begin
                    rd_mux = {27'h000_0000, mon};
                end
                default: begin
                    rd_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    // Answer one cycle after the request appears
    assign waitrequest = req & ~st_q.ack;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        st_d = st_q;
        sf = 1'b0;
        sr = 1'b0;
        // Bus slave: read data captured first, write lands with the ack
        st_d.ack = req & ~st_q.ack;
        if (read && !st_q.ack) begin
            st_d.rdata = rd_mux;
        end
        if (write && st_q.ack) begin
            if (slot[3]) begin
                st_d.asg[slot[2:0]] = writedata[10:0];
            end else if (address == `DTCL_OFS_CTRL) begin
                st_d.prot = writedata[`DTCL_CTRL_PROT];
                st_d.pol = writedata[`DTCL_CTRL_POL];
            end else if (address == `DTCL_OFS_DECEL) begin
                st_d.decel = writedata[15:0];
            end
        end

        // Millisecond enable for the forced-stop ramp
        st_d.tick_cnt = tick ? 15'h0000 : 15'(st_q.tick_cnt + 15'h0001);

        // 3-wire self-hold; without the hold command never latches
        st_d.fw_p = fw;
        st_d.rv_p = rv;
        if (!run_latch_enable) begin
            st_d.lf = 1'b0;
            st_d.lr = 1'b0;
        end else if (!st_q.lf && !st_q.lr) begin
            st_d.lf = fw & ~st_q.fw_p & ~(rv & ~st_q.rv_p);
            st_d.lr = rv & ~st_q.rv_p & ~(fw & ~st_q.fw_p);
        end

        // External trip holds until the reset command is released
        st_d.rst_p = fn_on[`DTCL_F_RST];
        st_d.trip = trip_now | (st_q.trip & ~rst_fall);

        // Forced stop: ramp, then alarm until reset
        case (st_q.fs)
            dtcl_pkg::DTCL_FS_IDLE: begin
                st_d.dcnt = 16'h0000;
                if (fs_in) begin
                    st_d.fs = dtcl_pkg::DTCL_FS_DECEL;
                end
            end
            dtcl_pkg::DTCL_FS_DECEL: begin
                if (tick) begin
                    st_d.dcnt = 16'(st_q.dcnt + 16'h0001);
                end
                if (motor_halted || st_q.dcnt >= st_q.decel) begin
                    st_d.fs = dtcl_pkg::DTCL_FS_ALARM;
                end
            end
            dtcl_pkg::DTCL_FS_ALARM: begin
                if (rst_fall && !fs_in) begin
                    st_d.fs = dtcl_pkg::DTCL_FS_IDLE;
                end
            end
            default: begin
                st_d.fs = dtcl_pkg::DTCL_FS_IDLE;
            end
        endcase

        // Fault relay: cleared by reset-on, new causes win the same cycle
        if (rst_rise) begin
            st_d.o.fault = 1'b0;
        end
        if (rst_fall) begin
            st_d.o.code = 8'h00;
        end
        if (trip_now && !st_q.trip) begin
            st_d.o.fault = 1'b1;
            st_d.o.code = `DTCL_ALM_EXT;
        end
        if (st_d.fs == dtcl_pkg::DTCL_FS_ALARM && st_q.fs != dtcl_pkg::DTCL_FS_ALARM) begin
            st_d.o.fault = 1'b1;
            st_d.o.code = `DTCL_ALM_FSTOP;
        end

        // Run source priority: link, keypad, alternate, terminals
        if (le) begin
            st_d.o.rsrc = dtcl_pkg::DTCL_RUN_COMM;
            sf = comm_fwd;
            sr = comm_rev;
        end else if (fn_on[`DTCL_F_LOC]) begin
            st_d.o.rsrc = dtcl_pkg::DTCL_RUN_KEYPAD;
            sf = keypad_fwd;
            sr = keypad_rev;
        end else if (fn_on[`DTCL_F_FR]) begin
            st_d.o.rsrc = dtcl_pkg::DTCL_RUN_ALT;
            sf = fn_on[`DTCL_F_ALT_RUN_FORWARD];
            sr = fn_on[`DTCL_F_ALT_RUN_REVERSE];
        end else begin
            st_d.o.rsrc = dtcl_pkg::DTCL_RUN_TERM;
            sf = fw | st_q.lf;
            sr = rv | st_q.lr;
        end

        // Frequency source priority: link, keypad, secondary, primary
        if (le) begin
            st_d.o.fsrc = dtcl_pkg::DTCL_FRQ_COMM;
        end else if (fn_on[`DTCL_F_LOC]) begin
            st_d.o.fsrc = dtcl_pkg::DTCL_FRQ_KEYPAD;
        end else if (fn_on[`DTCL_F_HZ]) begin
            st_d.o.fsrc = dtcl_pkg::DTCL_FRQ_SEC;
        end else begin
            st_d.o.fsrc = dtcl_pkg::DTCL_FRQ_PRI;
        end

        // Both directions at once means stop; any stop cause blocks run
        blocked = fn_on[`DTCL_F_BX] | st_d.trip | (st_d.fs != dtcl_pkg::DTCL_FS_IDLE);
        st_d.o.run_fwd = sf & ~sr & ~blocked;
        st_d.o.run_rev = sr & ~sf & ~blocked;
        run_now = st_d.o.run_fwd | st_d.o.run_rev;
        st_d.run_p = run_now;
        if (run_now && !st_q.run_p) begin
            st_d.o.ss = fn_on[`DTCL_F_STM];
        end

        // Coast: output stage off, no alarm for plain coast stop
        st_d.o.out_en = ~(fn_on[`DTCL_F_BX] | st_d.trip);
        st_d.o.decel = (st_d.fs == dtcl_pkg::DTCL_FS_DECEL);
        st_d.o.dcb = fn_on[`DTCL_F_DCB];
        st_d.o.heat = fn_on[`DTCL_F_DWP] & motor_halted;
        st_d.o.inv = (st_d.o.fsrc == dtcl_pkg::DTCL_FRQ_PRI) & (st_q.pol ^ fn_on[`DTCL_F_IVS]);
        st_d.o.restart = fn_on[`DTCL_F_IL];
        st_d.o.mon = mon;
        // Protect setting itself is always editable
        st_d.o.edit_ok = (~fn_asg[`DTCL_F_WEKP] | fn_on[`DTCL_F_WEKP]) & ~st_q.prot;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.asg <= {`DTCL_NTERM{`DTCL_ASG_NONE}};
            st_q.decel <= `DTCL_RST_DECEL;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign readdata = st_q.rdata;
    assign run_fwd_out = st_q.o.run_fwd;
    assign run_rev_out = st_q.o.run_rev;
    assign output_enable = st_q.o.out_en;
    assign forced_decel = st_q.o.decel;
    assign dc_brake_on = st_q.o.dcb;
    assign heating_on = st_q.o.heat;
    assign fault_relay_output = st_q.o.fault;
    assign alarm_code = st_q.o.code;
    assign freq_src = st_q.o.fsrc;
    assign analog_invert = st_q.o.inv;
    assign restart_enable = st_q.o.restart;
    assign speed_search_en = st_q.o.ss;
    assign run_src = st_q.o.rsrc;
    assign monitored_bits = st_q.o.mon;
    assign keypad_edit_allowed = st_q.o.edit_ok;
endmodule
`default_nettype wire

// File: verification/dtcl_switches.sv
// Model of the external switches wired to the programmable terminals
`timescale 1ns/1ps
`default_nettype none
module dtcl_switches #(
    parameter int HOLD = 40 // Cycles in 10 ms of shortened time
) (
    input wire logic clock, // Control clock
    input wire logic [4:0] lvl, // Wanted switch levels
    input wire logic rst_go, // Request one alarm reset
    output logic [4:0] term_in // Terminal pins
);
    int hold_cnt = 0;
    // Reset switch is held for the full span, never a short blip
    always @(posedge clock) begin
        if (rst_go && hold_cnt == 0) hold_cnt <= HOLD;
        else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
    end
    // Reset switch is on while a request is held or while lvl[4] is set
    assign term_in = {lvl[4] | (hold_cnt != 0), lvl[3:0]};
endmodule
`default_nettype wire

// File: verification/dtcl_core_asserts.sv
// Port checker of the terminal command logic
`timescale 1ns/1ps
`default_nettype none
`include "dtcl_defs.svh"
module dtcl_core_asserts (
    input wire logic clock, // Clock
    input wire logic resetn, // Reset, low
    input wire logic read, // Bus read
    input wire logic write, // Bus write
    input wire logic waitrequest, // Bus wait
    input wire logic motor_halted, // Standstill
    input wire logic run_fwd_out, // Run forward
    input wire logic run_rev_out, // Run reverse
    input wire logic output_enable, // Output on
    input wire logic forced_decel, // Stop ramp
    input wire logic heating_on, // Heating
    input wire logic fault_relay_output, // Fault relay
    input wire logic [7:0] alarm_code, // Alarm shown
    input wire logic [1:0] freq_src, // Freq source
    input wire logic analog_invert, // Inverse
    input wire logic speed_search_en // Search
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ****************************************
    // Bus handshake
    // ****************************************
    sequence bus_ask; (read || write) && waitrequest; endsequence
    sequence bus_take; (read || write) && !waitrequest; endsequence
    bus_wait_a: assert property (bus_ask |=> bus_take)
        else $error("bus answer late");
    bus_again_a: assert property (bus_take |=> !bus_take)
        else $error("bus taken twice");
    // ****************************************
    // Drive actions
    // ****************************************
    trip_off_a: assert property (alarm_code == `DTCL_ALM_EXT |-> !output_enable)
        else $error("output on during trip");
    fault_code_a: assert property ($rose(fault_relay_output) |-> alarm_code != 8'h00)
        else $error("fault without alarm code");
    alarm_run_a: assert property (alarm_code != 8'h00 |-> !(run_fwd_out || run_rev_out))
        else $error("run during alarm");
    decel_run_a: assert property (forced_decel |-> !run_fwd_out && !run_rev_out)
        else $error("run during forced stop");
    heat_halt_a: assert property (heating_on |-> $past(motor_halted))
        else $error("heating a turning motor");
    inv_pri_a: assert property (analog_invert |-> freq_src == 2'b00)
        else $error("inverse off primary");
    search_hold_a: assert property ((run_fwd_out || run_rev_out) && $past(run_fwd_out || run_rev_out)
        |-> $stable(speed_search_en)) else $error("search changed while running");
endmodule
bind dtcl_core dtcl_core_asserts u_dtcl_core_asserts (.clock, .resetn, .read, .write, .waitrequest,
    .motor_halted, .run_fwd_out, .run_rev_out, .output_enable, .forced_decel, .heating_on,
    .fault_relay_output, .alarm_code, .freq_src, .analog_invert, .speed_search_en);
`default_nettype wire

// File: verification/dtcl_core_bench.sv
// Self-checking bench of the terminal command logic
`timescale 1ns/1ps
`default_nettype none
`include "dtcl_defs.svh"
module dtcl_core_bench;
    localparam int TICK = 4;
    localparam logic [10:0] FN [7] = '{`DTCL_C_BX, `DTCL_C_DCB, `DTCL_C_WEKP, `DTCL_C_IL, `DTCL_C_UDI,
        `DTCL_C_LOC, `DTCL_C_DWP};
    logic clock = 0, resetn = 0, read = 0, write = 0, rst_go = 0, motor_halted = 0;
    logic run_forward_cmd = 0, run_reverse_cmd = 0, keypad_fwd = 0, keypad_rev = 0, comm_fwd = 0, comm_rev = 0;
    logic [7:0] address = 0, alarm_code;
    logic [31:0] writedata = 0, rd, readdata;
    logic [4:0] lvl = 0, term_in, monitored_bits;
    logic [1:0] freq_src, run_src;
    logic waitrequest, run_fwd_out, run_rev_out, output_enable, forced_decel, dc_brake_on, heating_on;
    logic fault_relay_output, analog_invert, restart_enable, speed_search_en, keypad_edit_allowed;
    int err_total = 0, cmp_count = 0;
    dtcl_core #(.TICK_CYCLES(TICK)) u_dtcl_core (.clock, .resetn, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .term_in, .run_forward_cmd, .run_reverse_cmd, .motor_halted, .keypad_fwd,
        .keypad_rev, .comm_fwd, .comm_rev, .run_fwd_out, .run_rev_out, .output_enable, .forced_decel,
        .dc_brake_on, .heating_on, .fault_relay_output, .alarm_code, .freq_src, .analog_invert,
        .restart_enable, .speed_search_en, .run_src, .monitored_bits, .keypad_edit_allowed);
    dtcl_switches #(.HOLD(10 * TICK)) u_dtcl_switches (.clock, .lvl, .rst_go, .term_in);
    // Clock of 50 ns
    initial forever #25 clock = ~clock;
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Bus access; wait and read data are taken at the rising edge that ends the request
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= wd;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clock);
            n++;
        end
        if (n == 20) err_total++;
        rd = readdata;
        read <= 0;
        write <= 0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(0, a, 32'h0000_0000);
        chk(rd, exp, "register");
    endtask
    task asg(input int t, input logic [10:0] c);
        bus(1, 8'(`DTCL_OFS_ASG0 + 4 * t), {21'h0, c});
    endtask
    // Pins pass 3 sync, 1 agreement filter and 1 output stage: 8 edges leave margin
    task pins(input logic [4:0] v, input logic f);
        @(posedge clock);
        lvl <= v;
        run_forward_cmd <= f;
        repeat (8) @(posedge clock);
        @(negedge clock);
    endtask
    task alarm_clear(input logic [7:0] code);
        @(posedge clock);
        rst_go <= 1;
        @(posedge clock);
        rst_go <= 0;
        repeat (20) @(posedge clock);
        @(negedge clock);
        chk(fault_relay_output, 0, "fault");
        chk(alarm_code, code, "alarm held");
        repeat (30) @(posedge clock);
        @(negedge clock);
        chk(alarm_code, 0, "alarm");
    endtask
    function logic effect(int k);
        case (k)
            0: effect = !output_enable && !fault_relay_output;
            1: effect = dc_brake_on;
            2: effect = keypad_edit_allowed;
            3: effect = restart_enable;
            4: effect = monitored_bits[1];
            5: effect = run_src == 2'b10 && freq_src == 2'b10;
            default: effect = heating_on;
        endcase
    endfunction
    // Watchdog
    initial begin
        repeat (10000) @(posedge clock);
        err_total++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1;
        rchk(`DTCL_OFS_CTRL, 32'h0000_0000);
        rchk(`DTCL_OFS_ASG0, 32'h0000_07FF);
        rchk(`DTCL_OFS_DECEL, 32'h0000_0064);
        rchk(8'h40, 32'h0000_0000);
        pins(0, 0);
        chk(run_src, 3, "run_src");
        chk(freq_src, 3, "freq_src");
        chk(keypad_edit_allowed, 1, "edit");
        bus(1, `DTCL_OFS_CTRL, 32'h0000_0001);
        pins(0, 0);
        chk(keypad_edit_allowed, 0, "edit");
        bus(1, `DTCL_OFS_CTRL, 32'h0000_0000);
        asg(0, `DTCL_C_LE);
        pins(0, 1);
        chk(freq_src, 0, "freq_src");
        chk(run_fwd_out, 1, "run");
        pins(0, 0);
        chk(run_fwd_out, 0, "run");
        asg(1, `DTCL_C_HZ);
        pins(5'b00010, 0);
        chk(freq_src, 1, "freq_src");
        asg(2, `DTCL_C_IVS);
        pins(5'b00100, 0);
        chk(analog_invert, 1, "invert");
        bus(1, `DTCL_OFS_CTRL, 32'h0000_0002);
        pins(5'b00100, 0);
        chk(analog_invert, 0, "invert");
        pins(5'b00010, 0);
        chk(analog_invert, 0, "invert");
        bus(1, `DTCL_OFS_CTRL, 32'h0000_0000);
        asg(2, `DTCL_C_HLD);
        pins(5'b00100, 0);
        pins(5'b00100, 1);
        pins(5'b00100, 0);
        chk(run_fwd_out, 1, "latched run");
        pins(0, 0);
        chk(run_fwd_out, 0, "latched run");
        pins(5'b01000, 0);
        asg(3, `DTCL_C_THR);
        asg(4, `DTCL_C_RST);
        pins(0, 0);
        chk(output_enable, 0, "output");
        chk(fault_relay_output, 1, "fault");
        chk(alarm_code, `DTCL_ALM_EXT, "alarm");
        pins(5'b01000, 0);
        chk(fault_relay_output, 1, "fault");
        alarm_clear(`DTCL_ALM_EXT);
        chk(output_enable, 1, "output");
        asg(3, `DTCL_C_THR + `DTCL_NEG_OFS);
        pins(5'b01000, 0);
        chk(alarm_code, `DTCL_ALM_EXT, "alarm");
        pins(0, 0);
        alarm_clear(`DTCL_ALM_EXT);
        // Single-purpose commands on one terminal, on then off
        @(posedge clock) motor_halted <= 1;
        for (int k = 0; k < 7; k++) begin
            asg(1, FN[k]);
            pins(5'b00010, 0);
            chk(effect(k), 1, "on");
            pins(0, 0);
            chk(effect(k), 0, "off");
        end
        @(posedge clock) motor_halted <= 0;
        asg(3, `DTCL_C_STM);
        asg(1, `DTCL_C_FR);
        asg(2, `DTCL_C_ALT_RUN_FORWARD);
        pins(5'b01110, 0);
        chk(run_src, 1, "run_src");
        chk(run_fwd_out, 1, "run");
        chk(speed_search_en, 1, "search");
        pins(5'b00010, 0);
        chk(run_fwd_out, 0, "run");
        pins(5'b01000, 0);
        asg(3, `DTCL_C_STOP);
        bus(1, `DTCL_OFS_DECEL, 32'h0000_0005);
        pins(0, 0);
        chk(forced_decel, 1, "ramp");
        chk(fault_relay_output, 0, "fault");
        repeat (25) @(posedge clock);
        @(negedge clock);
        chk(alarm_code, `DTCL_ALM_FSTOP, "alarm");
        pins(5'b01000, 0);
        alarm_clear(`DTCL_ALM_FSTOP);
        report_and_stop;
    end
endmodule
`default_nettype wire
